// File: src/rfc_bank.sv
`timescale 1ns/1ps
// Behaviour
// - Base-rate field is an unsigned 16-bit count of hertz.
// - Multi-byte fields are big-endian: MSB at the lowest address.
// - Multiplier is an unsigned 16-bit factor applied to the base rate.
// - Ratio word: numerator in bits 31:16, denominator in 15:0.
// - Nominal frequency is base times multiplier times numerator over denominator.
// - Each input owns a separate value set; input 0 has only its ratio writable, its base and multiplier come from parameters.
module rfc_bank #(
  parameter logic [15:0] IN0_BASE_RATE = rfc_pkg::RST_BASE_RATE,
  parameter logic [15:0] IN0_RATE_MULT = rfc_pkg::RST_IN0_MULT
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd_en,
  output logic [7:0]       reg_rdata,
  output logic             reg_rd_valid,
  // Applied values
  output logic [15:0]      input0_fec_numerator,
  output logic [15:0]      input0_fec_denominator,
  output logic [15:0]      input1_base_rate,
  output logic [15:0]      input1_rate_multiplier,
  output logic [15:0]      input1_fec_numerator,
  output logic [15:0]      input1_fec_denominator,
  output logic [15:0]      input2_base_rate,
  output logic [15:0]      input2_rate_multiplier,
  output logic [15:0]      input2_fec_numerator,
  output logic [15:0]      input2_fec_denominator,
  // Nominal frequencies
  output logic [47:0]      nominal_freq0_hz,
  output logic [47:0]      nominal_freq1_hz,
  output logic [47:0]      nominal_freq2_hz,
  output logic [2:0]       freq_valid,
  output logic [2:0]       ratio_error
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic [5:0] bank_index(input logic [7:0] a);
    logic hit;
    hit = (a >= rfc_pkg::OFS_IN0_RATIO) && (a <= rfc_pkg::OFS_LAST);
    return {hit, 5'(a - rfc_pkg::OFS_IN0_RATIO)};
  endfunction : bank_index

  logic [5:0] dec;
  logic       wr_hit;
  logic [4:0] idx;
  assign dec    = bank_index(reg_addr);
  assign wr_hit = reg_wr_en && dec[5];
  assign idx    = dec[4:0];

  // ****************************************************************
  // Byte staging, as software wrote it
  // ****************************************************************
  logic [7:0] stage_reg  [rfc_pkg::BANK_BYTES];
  logic [7:0] stage_next [rfc_pkg::BANK_BYTES];

  always_comb begin
    stage_next = stage_reg;
    if (wr_hit) begin
      stage_next[idx] = reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < rfc_pkg::BANK_BYTES; i++) begin
        stage_reg[i] <= rfc_pkg::BANK_RESET[159 - 8 * i -: 8];
      end
    end else begin
      stage_reg <= stage_next;
    end
  end

  // ****************************************************************
  // Applied fields, updated on the last byte only
  // ****************************************************************
  function automatic logic [15:0] word16(input logic [4:0] i);
    return {stage_next[i], stage_next[5'(i + 5'h01)]};
  endfunction : word16

  logic [31:0] ratio_reg [rfc_pkg::NUM_INPUTS];
  logic [31:0] ratio_next[rfc_pkg::NUM_INPUTS];
  logic [15:0] base_reg  [rfc_pkg::NUM_INPUTS];
  logic [15:0] base_next [rfc_pkg::NUM_INPUTS];
  logic [15:0] mult_reg  [rfc_pkg::NUM_INPUTS];
  logic [15:0] mult_next [rfc_pkg::NUM_INPUTS];
  logic [2:0]  commit;

  // Partial writes leave the applied copies untouched
  always_comb begin
    ratio_next = ratio_reg;
    base_next  = base_reg;
    mult_next  = mult_reg;
    commit     = '0;
    if (wr_hit) begin
      case (idx)
        rfc_pkg::IDX_IN0_RATIO + rfc_pkg::LSB32: begin
          ratio_next[0] = {word16(rfc_pkg::IDX_IN0_RATIO),
                           word16(rfc_pkg::IDX_IN0_RATIO + 5'h02)};
          commit[0] = 1'b1;
        end
        rfc_pkg::IDX_IN1_BASE + rfc_pkg::LSB16: begin
          base_next[1] = word16(rfc_pkg::IDX_IN1_BASE);
          commit[1] = 1'b1;
        end
        rfc_pkg::IDX_IN1_MULT + rfc_pkg::LSB16: begin
          mult_next[1] = word16(rfc_pkg::IDX_IN1_MULT);
          commit[1] = 1'b1;
        end
        rfc_pkg::IDX_IN1_RATIO + rfc_pkg::LSB32: begin
          ratio_next[1] = {word16(rfc_pkg::IDX_IN1_RATIO),
                           word16(rfc_pkg::IDX_IN1_RATIO + 5'h02)};
          commit[1] = 1'b1;
        end
        rfc_pkg::IDX_IN2_BASE + rfc_pkg::LSB16: begin
          base_next[2] = word16(rfc_pkg::IDX_IN2_BASE);
          commit[2] = 1'b1;
        end
        rfc_pkg::IDX_IN2_MULT + rfc_pkg::LSB16: begin
          mult_next[2] = word16(rfc_pkg::IDX_IN2_MULT);
          commit[2] = 1'b1;
        end
        rfc_pkg::IDX_IN2_RATIO + rfc_pkg::LSB32: begin
          ratio_next[2] = {word16(rfc_pkg::IDX_IN2_RATIO),
                           word16(rfc_pkg::IDX_IN2_RATIO + 5'h02)};
          commit[2] = 1'b1;
        end
        default: begin
          commit = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < rfc_pkg::NUM_INPUTS; i++) begin
        ratio_reg[i] <= rfc_pkg::RST_FEC_RATIO;
        base_reg[i]  <= rfc_pkg::RST_BASE_RATE;
        mult_reg[i]  <= rfc_pkg::RST_RATE_MULT;
      end
      // Input 0 base and multiplier live outside this bank
      base_reg[0] <= IN0_BASE_RATE;
      mult_reg[0] <= IN0_RATE_MULT;
    end else begin
      ratio_reg <= ratio_next;
      base_reg  <= base_next;
      mult_reg  <= mult_next;
    end
  end

  assign input0_fec_numerator   = ratio_reg[0][31:16];
  assign input0_fec_denominator = ratio_reg[0][15:0];
  assign input1_base_rate       = base_reg[1];
  assign input1_rate_multiplier = mult_reg[1];
  assign input1_fec_numerator   = ratio_reg[1][31:16];
  assign input1_fec_denominator = ratio_reg[1][15:0];
  assign input2_base_rate       = base_reg[2];
  assign input2_rate_multiplier = mult_reg[2];
  assign input2_fec_numerator   = ratio_reg[2][31:16];
  assign input2_fec_denominator = ratio_reg[2][15:0];

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;

  always_comb begin
    rvalid_next = reg_rd_en;
    rdata_next  = 8'h00;
    if (reg_rd_en && dec[5]) begin
      rdata_next = stage_reg[idx];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata    = rdata_reg;
  assign reg_rd_valid = rvalid_reg;

  // ****************************************************************
  // Nominal frequency scheduling
  // ****************************************************************
  logic [2:0]  dirty_reg, dirty_next;
  logic [1:0]  cur_reg, cur_next, pick;
  logic [47:0] freq_reg [rfc_pkg::NUM_INPUTS];
  logic [47:0] freq_next[rfc_pkg::NUM_INPUTS];
  logic [2:0]  valid_reg, valid_next, err_reg, err_next;
  logic        launch, calc_busy, calc_done, calc_zero;
  logic [47:0] calc_freq;

  assign pick   = dirty_reg[0] ? 2'h0 : (dirty_reg[1] ? 2'h1 : 2'h2);
  assign launch = !calc_busy && (dirty_reg != '0);

  // A commit landing with a launch re-arms the input: set beats clear
  always_comb begin
    dirty_next = dirty_reg;
    cur_next   = cur_reg;
    freq_next  = freq_reg;
    valid_next = valid_reg & ~commit;
    err_next   = err_reg;
    if (launch) begin
      dirty_next[pick] = 1'b0;
      cur_next         = pick;
    end
    if (calc_done) begin
      freq_next[cur_reg]  = calc_freq;
      err_next[cur_reg]   = calc_zero;
      valid_next[cur_reg] = !calc_zero && !dirty_reg[cur_reg]
                            && !commit[cur_reg];
    end
    dirty_next = dirty_next | commit;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      dirty_reg <= 3'h7;
      cur_reg   <= 2'h0;
      valid_reg <= 3'h0;
      err_reg   <= 3'h0;
      for (int i = 0; i < rfc_pkg::NUM_INPUTS; i++) begin
        freq_reg[i] <= '0;
      end
    end else begin
      dirty_reg <= dirty_next;
      cur_reg   <= cur_next;
      valid_reg <= valid_next;
      err_reg   <= err_next;
      freq_reg  <= freq_next;
    end
  end

  rfc_freq_calc u_calc (
    .clock           (clock),
    .resetn          (resetn),
    .start           (launch),
    .base_rate_hz    (base_reg[pick]),
    .rate_multiplier (mult_reg[pick]),
    .fec_numerator   (ratio_reg[pick][31:16]),
    .fec_denominator (ratio_reg[pick][15:0]),
    .busy            (calc_busy),
    .done            (calc_done),
    .freq_hz         (calc_freq),
    .den_zero        (calc_zero)
  );

  assign nominal_freq0_hz = freq_reg[0];
  assign nominal_freq1_hz = freq_reg[1];
  assign nominal_freq2_hz = freq_reg[2];
  assign freq_valid       = valid_reg;
  assign ratio_error      = err_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_wr(logic [7:0] a);
    reg_wr_en && reg_addr == a;
  endsequence

  sequence s_in2_ratio_msb;
    s_wr(rfc_pkg::OFS_IN2_RATIO) ##1 !reg_wr_en;
  endsequence

  AST_BASE1_COMMIT: assert property (
    s_wr(rfc_pkg::OFS_IN1_BASE + 8'h01) |=>
      input1_base_rate == {$past(stage_reg[4]), $past(reg_wdata)})
    else $error("base rate not applied from its two bytes");

  AST_MSB_LOW_ADDR: assert property (
    s_wr(rfc_pkg::OFS_IN2_MULT) ##1 s_wr(rfc_pkg::OFS_IN2_MULT + 8'h01)
      |=> input2_rate_multiplier[15:8] == $past(reg_wdata, 2))
    else $error("lower address did not land in high byte");

  AST_MULT1_COMMIT: assert property (
    s_wr(rfc_pkg::OFS_IN1_MULT + 8'h01) |=>
      input1_rate_multiplier[7:0] == $past(reg_wdata))
    else $error("multiplier low byte not applied");

  AST_RATIO_SPLIT: assert property (
    s_wr(rfc_pkg::OFS_IN2_RATIO + 8'h03) |=>
      input2_fec_numerator == {$past(stage_reg[16]), $past(stage_reg[17])}
      && input2_fec_denominator[7:0] == $past(reg_wdata))
    else $error("ratio fields misplaced");

  AST_SETS_APART: assert property (
    reg_wr_en && reg_addr >= rfc_pkg::OFS_IN1_BASE
      && reg_addr < rfc_pkg::OFS_IN2_BASE |=>
      $stable(input2_base_rate) && $stable(input2_fec_denominator))
    else $error("write to input 1 disturbed input 2");

  AST_NO_PARTIAL: assert property (
    s_in2_ratio_msb |-> $stable(input2_fec_numerator))
    else $error("partial write reached applied value");

  AST_RESULT_STORED: assert property (
    calc_done && !calc_zero |=> freq_reg[$past(cur_reg)] == $past(calc_freq))
    else $error("finished frequency not stored");

endmodule : rfc_bank

// File: src/rfc_pkg.sv
package rfc_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int BYTE_W     = 8;
  localparam int FIELD_W    = 16;
  localparam int RATIO_W    = 32;
  localparam int FREQ_W     = 48;
  localparam int NUM_INPUTS = 3;
  localparam int BANK_BYTES = 20;

  // ****************************************************************
  // Byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_IN0_RATIO = 8'h14;
  localparam logic [7:0] OFS_IN1_BASE  = 8'h18;
  localparam logic [7:0] OFS_IN1_MULT  = 8'h1A;
  localparam logic [7:0] OFS_IN1_RATIO = 8'h1C;
  localparam logic [7:0] OFS_IN2_BASE  = 8'h20;
  localparam logic [7:0] OFS_IN2_MULT  = 8'h22;
  localparam logic [7:0] OFS_IN2_RATIO = 8'h24;
  localparam logic [7:0] OFS_LAST      = 8'h27;

  // Index of each field's first byte inside the bank
  localparam logic [4:0] IDX_IN0_RATIO = 5'(OFS_IN0_RATIO - OFS_IN0_RATIO);
  localparam logic [4:0] IDX_IN1_BASE  = 5'(OFS_IN1_BASE - OFS_IN0_RATIO);
  localparam logic [4:0] IDX_IN1_MULT  = 5'(OFS_IN1_MULT - OFS_IN0_RATIO);
  localparam logic [4:0] IDX_IN1_RATIO = 5'(OFS_IN1_RATIO - OFS_IN0_RATIO);
  localparam logic [4:0] IDX_IN2_BASE  = 5'(OFS_IN2_BASE - OFS_IN0_RATIO);
  localparam logic [4:0] IDX_IN2_MULT  = 5'(OFS_IN2_MULT - OFS_IN0_RATIO);
  localparam logic [4:0] IDX_IN2_RATIO = 5'(OFS_IN2_RATIO - OFS_IN0_RATIO);
  localparam logic [4:0] LSB16         = 5'h01;
  localparam logic [4:0] LSB32         = 5'h03;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_BASE_RATE = 16'h9C40;
  localparam logic [15:0] RST_RATE_MULT = 16'h01E6;
  localparam logic [31:0] RST_FEC_RATIO = 32'h00010001;
  localparam logic [15:0] RST_IN0_MULT  = 16'h0F30;
  localparam logic [159:0] BANK_RESET  = {RST_FEC_RATIO,
    RST_BASE_RATE, RST_RATE_MULT, RST_FEC_RATIO,
    RST_BASE_RATE, RST_RATE_MULT, RST_FEC_RATIO};

  // ****************************************************************
  // Frequency calculator
  // ****************************************************************
  localparam logic [5:0] CALC_LAST_STEP = 6'(FREQ_W - 1);

  typedef enum logic [1:0] {
    RFC_CALC_IDLE = 2'b00,
    RFC_CALC_RUN  = 2'b01,
    RFC_CALC_DONE = 2'b11
  } rfc_calc_state_t;

endpackage : rfc_pkg

// File: src/rfc_freq_calc.sv
`timescale 1ns/1ps
module rfc_freq_calc (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Request
  input  wire logic        start,
  input  wire logic [15:0] base_rate_hz,
  input  wire logic [15:0] rate_multiplier,
  input  wire logic [15:0] fec_numerator,
  input  wire logic [15:0] fec_denominator,
  // Answer
  output logic             busy,
  output logic             done,
  output logic [47:0]      freq_hz,
  output logic             den_zero
);

  // ****************************************************************
  // Restoring divider, one quotient bit per cycle
  // ****************************************************************
  rfc_pkg::rfc_calc_state_t state_reg, state_next;
  logic [47:0] quo_reg, quo_next;
  logic [15:0] rem_reg, rem_next;
  logic [15:0] den_reg, den_next;
  logic [47:0] dvd_reg, dvd_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic        zero_reg, zero_next;
  logic [16:0] rem_sh;
  logic [47:0] product;

  assign product = 48'(base_rate_hz) * 48'(rate_multiplier)
                 * 48'(fec_numerator);
  assign rem_sh  = {rem_reg, quo_reg[47]};

  always_comb begin
    state_next = state_reg;
    quo_next   = quo_reg;
    rem_next   = rem_reg;
    den_next   = den_reg;
    dvd_next   = dvd_reg;
    cnt_next   = cnt_reg;
    zero_next  = zero_reg;
    case (state_reg)
      rfc_pkg::RFC_CALC_IDLE: begin
        if (start) begin
          // Operands latched so later commits cannot tear a result
          quo_next  = product;
          dvd_next  = product;
          den_next  = fec_denominator;
          rem_next  = '0;
          cnt_next  = rfc_pkg::CALC_LAST_STEP;
          zero_next = (fec_denominator == '0);
          if (fec_denominator == '0) begin
            quo_next   = '0;
            state_next = rfc_pkg::RFC_CALC_DONE;
          end else begin
            state_next = rfc_pkg::RFC_CALC_RUN;
          end
        end
      end
      rfc_pkg::RFC_CALC_RUN: begin
        if (rem_sh >= {1'b0, den_reg}) begin
          rem_next = 16'(rem_sh - {1'b0, den_reg});
          quo_next = {quo_reg[46:0], 1'b1};
        end else begin
          rem_next = rem_sh[15:0];
          quo_next = {quo_reg[46:0], 1'b0};
        end
        cnt_next = cnt_reg - 6'h01;
        if (cnt_reg == '0) begin
          state_next = rfc_pkg::RFC_CALC_DONE;
        end
      end
      rfc_pkg::RFC_CALC_DONE: begin
        state_next = rfc_pkg::RFC_CALC_IDLE;
      end
      default: begin
        state_next = rfc_pkg::RFC_CALC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= rfc_pkg::RFC_CALC_IDLE;
      quo_reg   <= '0;
      rem_reg   <= '0;
      den_reg   <= '0;
      dvd_reg   <= '0;
      cnt_reg   <= '0;
      zero_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      quo_reg   <= quo_next;
      rem_reg   <= rem_next;
      den_reg   <= den_next;
      dvd_reg   <= dvd_next;
      cnt_reg   <= cnt_next;
      zero_reg  <= zero_next;
    end
  end

  assign busy     = (state_reg != rfc_pkg::RFC_CALC_IDLE);
  assign done     = (state_reg == rfc_pkg::RFC_CALC_DONE);
  assign freq_hz  = quo_reg;
  assign den_zero = zero_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_QUOTIENT: assert property (@(posedge clock) disable iff (!resetn)
    done && !den_zero |->
      64'(freq_hz) * 64'(den_reg) + 64'(rem_reg) == 64'(dvd_reg))
    else $error("quotient times denominator misses product");

  AST_CALC_TIME: assert property (@(posedge clock) disable iff (!resetn)
    start && !busy && fec_denominator != '0 |-> ##49 done)
    else $error("division did not finish in 49 cycles");

endmodule : rfc_freq_calc

// File: test/ref_freq_config_regs_bench.sv
`timescale 1ns/1ps
module ref_freq_config_regs_bench;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clock;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic        reg_wr_en;
  logic [7:0]  reg_wdata;
  logic        reg_rd_en;
  logic [7:0]  reg_rdata;
  logic        reg_rd_valid;
  logic [15:0] in0_num, in0_den, in1_base, in1_mult, in1_num, in1_den;
  logic [15:0] in2_base, in2_mult, in2_num, in2_den;
  logic [47:0] freq0, freq1, freq2;
  logic [2:0]  freq_valid;
  logic [2:0]  ratio_error;
  int          failures;
  int          checked;

  // Bank image after reset, lowest address in the top byte
  localparam logic [159:0] BANK_IMAGE =
    160'h00010001_9C40_01E6_00010001_9C40_01E6_00010001;

  rfc_bank dut (
    .clock                  (clock),
    .resetn                 (resetn),
    .reg_addr               (reg_addr),
    .reg_wr_en              (reg_wr_en),
    .reg_wdata              (reg_wdata),
    .reg_rd_en              (reg_rd_en),
    .reg_rdata              (reg_rdata),
    .reg_rd_valid           (reg_rd_valid),
    .input0_fec_numerator   (in0_num),
    .input0_fec_denominator (in0_den),
    .input1_base_rate       (in1_base),
    .input1_rate_multiplier (in1_mult),
    .input1_fec_numerator   (in1_num),
    .input1_fec_denominator (in1_den),
    .input2_base_rate       (in2_base),
    .input2_rate_multiplier (in2_mult),
    .input2_fec_numerator   (in2_num),
    .input2_fec_denominator (in2_den),
    .nominal_freq0_hz       (freq0),
    .nominal_freq1_hz       (freq1),
    .nominal_freq2_hz       (freq2),
    .freq_valid             (freq_valid),
    .ratio_error            (ratio_error)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(string what, logic [47:0] exp, logic [47:0] seen);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Integer quotient, as the calculator truncates
  function automatic logic [47:0] nominal(logic [15:0] b, logic [15:0] m,
                                          logic [15:0] n, logic [15:0] d);
    logic [63:0] p;
    p = 64'(b) * 64'(m) * 64'(n);
    return 48'(p / 64'(d));
  endfunction : nominal

  task automatic wr_byte(logic [7:0] addr, logic [7:0] data);
    @(negedge clock);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
  endtask : wr_byte

  // Each read is one strobe; the answer stands for the following cycle
  task automatic rd_chk(logic [7:0] addr, logic [7:0] exp);
    @(negedge clock);
    reg_addr  = addr;
    reg_rd_en = 1'b1;
    @(negedge clock);
    reg_rd_en = 1'b0;
    chk("rd_valid", 48'h1, 48'(reg_rd_valid));
    chk($sformatf("rdata@%h", addr), 48'(exp), 48'(reg_rdata));
  endtask : rd_chk

  // Calculator takes about fifty cycles per input; bound well above that
  task automatic wait_valid(int idx);
    int n;
    for (n = 0; n < 600 && freq_valid[idx] !== 1'b1; n++) begin
      @(negedge clock);
    end
    if (freq_valid[idx] !== 1'b1) begin
      failures++;
      $display("MISMATCH freq_valid[%0d] expected 1 seen %b", idx,
               freq_valid[idx]);
      final_report();
    end
  endtask : wait_valid

  task automatic do_reset();
    @(negedge clock);
    resetn = 1'b0;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
  endtask : do_reset

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic sc_reset_values();
    int i;
    for (i = 0; i < 20; i++) begin
      rd_chk(8'h14 + 8'(i), BANK_IMAGE[159 - 8 * i -: 8]);
    end
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h28, 8'h00);
    chk("in1_mult", 48'h01E6, 48'(in1_mult));
    chk("in2_den", 48'h0001, 48'(in2_den));
  endtask : sc_reset_values

  task automatic sc_default_freqs();
    wait_valid(0);
    wait_valid(1);
    wait_valid(2);
    chk("freq0", nominal(16'h9C40, 16'h0F30, 16'h1, 16'h1), freq0);
    chk("freq1", nominal(16'h9C40, 16'h01E6, 16'h1, 16'h1), freq1);
    chk("freq2", 48'h0000_0128_A180, freq2);
  endtask : sc_default_freqs

  task automatic sc_big_endian_base();
    wr_byte(8'h18, 8'h1F);
    chk("in1_base staged", 48'h9C40, 48'(in1_base));
    rd_chk(8'h18, 8'h1F);
    wr_byte(8'h19, 8'h40);
    chk("in1_base", 48'h1F40, 48'(in1_base));
    chk("valid1 cleared", 48'h0, 48'(freq_valid[1]));
    chk("in2_base", 48'h9C40, 48'(in2_base));
    wait_valid(1);
    chk("freq1", nominal(16'h1F40, 16'h01E6, 16'h1, 16'h1), freq1);
    chk("freq2 kept", 48'h0000_0128_A180, freq2);
  endtask : sc_big_endian_base

  task automatic sc_fec_ratio();
    wr_byte(8'h22, 8'h0F);
    wr_byte(8'h23, 8'h30);
    wr_byte(8'h24, 8'h00);
    wr_byte(8'h25, 8'hFF);
    wr_byte(8'h26, 8'h00);
    chk("in2_num staged", 48'h0001, 48'(in2_num));
    wr_byte(8'h27, 8'hED);
    chk("in2_num", 48'h00FF, 48'(in2_num));
    chk("in2_den", 48'h00ED, 48'(in2_den));
    chk("in1_num", 48'h0001, 48'(in1_num));
    chk("in1_den", 48'h0001, 48'(in1_den));
    wait_valid(2);
    chk("freq2", nominal(16'h9C40, 16'h0F30, 16'h00FF, 16'h00ED),
        freq2);
  endtask : sc_fec_ratio

  task automatic sc_zero_denominator();
    int i;
    logic [31:0] bad;
    bad = 32'h0002_0000;
    for (i = 0; i < 4; i++) begin
      wr_byte(8'h14 + 8'(i), bad[31 - 8 * i -: 8]);
    end
    chk("in0_num", 48'h0002, 48'(in0_num));
    chk("in0_den", 48'h0000, 48'(in0_den));
    repeat (200) @(negedge clock);
    chk("ratio_error0", 48'h1, 48'(ratio_error[0]));
    chk("valid0", 48'h0, 48'(freq_valid[0]));
    for (i = 0; i < 4; i++) begin
      wr_byte(8'h14 + 8'(i), (i % 2 == 1) ? 8'h01 : 8'h00);
    end
    wait_valid(0);
    chk("ratio_error0", 48'h0, 48'(ratio_error[0]));
    chk("freq0", nominal(16'h9C40, 16'h0F30, 16'h1, 16'h1), freq0);
  endtask : sc_zero_denominator

  task automatic sc_unmapped_and_rereset();
    wr_byte(8'h28, 8'h5A);
    wr_byte(8'h13, 8'hA5);
    rd_chk(8'h28, 8'h00);
    rd_chk(8'h13, 8'h00);
    rd_chk(8'h1B, 8'hE6);
    // Input 1 multiplier reprogrammed from its reset value 486 to 243
    wr_byte(8'h1A, 8'h00);
    wr_byte(8'h1B, 8'hF3);
    chk("in1_mult", 48'h00F3, 48'(in1_mult));
    // Reset mid-run must bring the staged bytes back as well
    do_reset();
    rd_chk(8'h1A, 8'h01);
    rd_chk(8'h18, 8'h9C);
    chk("in1_mult", 48'h01E6, 48'(in1_mult));
  endtask : sc_unmapped_and_rereset

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    failures  = 0;
    checked   = 0;
    resetn    = 1'b0;
    reg_addr  = 8'h00;
    reg_wr_en = 1'b0;
    reg_wdata = 8'h00;
    reg_rd_en = 1'b0;
    do_reset();
    sc_reset_values();
    sc_default_freqs();
    sc_big_endian_base();
    sc_fec_ratio();
    sc_zero_denominator();
    sc_unmapped_and_rereset();
    final_report();
  end

endmodule : ref_freq_config_regs_bench
